// *** rtl/uil_interrupt_level_mask_status.sv ***
// Interrupt trigger levels, mask, raw status and clear for the serial port
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
module uil_interrupt_level_mask_status (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic [11:0] regAddress,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regReadData,
    // Events from the receive and error logic
    input wire logic overrunEvent,
    input wire logic breakErrEvent,
    input wire logic parityErrEvent,
    input wire logic framingErrEvent,
    input wire logic rxTimeoutEvent,
    // FIFO fill levels, 0 to 16 entries
    input wire logic [4:0] rxFillLevel,
    input wire logic [4:0] txFillLevel,
    // Interrupt controller outputs
    output logic [6:0] maskedInterrupt,
    output logic interruptOut
);
    logic [2:0] rx_trigger_level; // Receive threshold code
    logic [2:0] tx_trigger_level; // Transmit threshold code
    logic [6:0] interrupt_mask; // One bit per source, receive at index 0
    logic [6:0] raw_interrupt_status; // Sticky raw state
    logic rxCrossed; // Receive threshold crossing pulse
    logic txCrossed; // Transmit threshold crossing pulse
    logic [6:0] eventVector; // All events in register order
    logic [6:0] clearVector; // Write-one-to-clear request
    logic [6:0] next_raw; // Next raw state
    logic [6:0] next_mask; // Mask as it stands after this edge
    logic [31:0] next_readData; // Read mux result

    // Shared address decode for a write at one offset
    function automatic logic writeHit(input logic [11:0] offset);
        writeHit = regWrite && (regAddress == offset);
    endfunction

    // Receive level crossing
    uil_threshold_cross rxCross (
        .clock(clock),
        .reset(reset),
        .levelCode(rx_trigger_level),
        .fillLevel(rxFillLevel),
        .isTransmit(1'b0),
        .crossed(rxCrossed)
    );

    // Transmit level crossing
    uil_threshold_cross txCross (
        .clock(clock),
        .reset(reset),
        .levelCode(tx_trigger_level),
        .fillLevel(txFillLevel),
        .isTransmit(1'b1),
        .crossed(txCrossed)
    );

    // Trigger level register; reserved codes are stored but act as half full
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_trigger_level <= uil_pkg::LEVEL_RESET;
            tx_trigger_level <= uil_pkg::LEVEL_RESET;
        end else if (writeHit(uil_pkg::TRIGGER_LEVEL_OFFSET)) begin
            rx_trigger_level <= regWriteData[uil_pkg::RX_LEVEL_LSB +: uil_pkg::LEVEL_WIDTH];
            tx_trigger_level <= regWriteData[uil_pkg::TX_LEVEL_LSB +: uil_pkg::LEVEL_WIDTH];
        end
    end

    // Mask register; only bits 10:4 are stored
    always_ff @(posedge clock) begin
        if (reset) begin
            interrupt_mask <= uil_pkg::MASK_RESET;
        end else if (writeHit(uil_pkg::MASK_OFFSET)) begin
            interrupt_mask <= regWriteData[uil_pkg::SRC_LSB +: uil_pkg::SRC_COUNT];
        end
    end

    // Gather events and clear requests in register bit order
    always_comb begin
        eventVector = 7'h00;
        eventVector[uil_pkg::RX_LEVEL_BIT] = rxCrossed;
        eventVector[uil_pkg::TX_LEVEL_BIT] = txCrossed;
        eventVector[uil_pkg::RX_TIMEOUT_BIT] = rxTimeoutEvent;
        eventVector[uil_pkg::FRAMING_BIT] = framingErrEvent;
        eventVector[uil_pkg::PARITY_BIT] = parityErrEvent;
        eventVector[uil_pkg::BREAK_BIT] = breakErrEvent;
        eventVector[uil_pkg::OVERRUN_BIT] = overrunEvent;
        // Outputs follow a mask write at once, so a zero mask blocks with no lag
        next_mask = interrupt_mask;
        if (writeHit(uil_pkg::MASK_OFFSET)) begin
            next_mask = regWriteData[uil_pkg::SRC_LSB +: uil_pkg::SRC_COUNT];
        end
        clearVector = 7'h00;
        if (writeHit(uil_pkg::CLEAR_OFFSET)) begin
            clearVector = regWriteData[uil_pkg::SRC_LSB +: uil_pkg::SRC_COUNT];
        end
        // A new event beats a clear in the same cycle so no event is lost
        next_raw = (raw_interrupt_status & ~clearVector) | eventVector;
    end

    // Raw status; a write at its own offset never reaches it
    always_ff @(posedge clock) begin
        if (reset) begin
            raw_interrupt_status <= uil_pkg::RAW_RESET;
        end else begin
            raw_interrupt_status <= next_raw;
        end
    end

    // Interrupt outputs, registered from the next state so they track status
    always_ff @(posedge clock) begin
        if (reset) begin
            maskedInterrupt <= 7'h00;
            interruptOut <= 1'b0;
        end else begin
            maskedInterrupt <= next_raw & next_mask;
            interruptOut <= |(next_raw & next_mask);
        end
    end

    // Read mux
    always_comb begin
        next_readData = 32'h0000_0000;
        case (regAddress)
            uil_pkg::TRIGGER_LEVEL_OFFSET: begin
                // Upper bits are undefined to software; zero is returned
                next_readData[uil_pkg::RX_LEVEL_LSB +: uil_pkg::LEVEL_WIDTH] = rx_trigger_level;
                next_readData[uil_pkg::TX_LEVEL_LSB +: uil_pkg::LEVEL_WIDTH] = tx_trigger_level;
            end
            uil_pkg::MASK_OFFSET: begin
                next_readData[uil_pkg::SRC_LSB +: uil_pkg::SRC_COUNT] = interrupt_mask;
            end
            uil_pkg::RAW_STATUS_OFFSET: begin
                next_readData[uil_pkg::SRC_LSB +: uil_pkg::SRC_COUNT] = raw_interrupt_status;
                next_readData[3:0] = uil_pkg::RAW_LOW_FIELD;
            end
            uil_pkg::MASKED_STATUS_OFFSET: begin
                next_readData[uil_pkg::SRC_LSB +: uil_pkg::SRC_COUNT] =
                    raw_interrupt_status & interrupt_mask;
            end
            default: begin
                // Clear register and unmapped offsets read as zero
                next_readData = 32'h0000_0000;
            end
        endcase
    end

    // Read data stands only in the cycle after the read strobe
    always_ff @(posedge clock) begin
        if (reset) begin
            regReadData <= 32'h0000_0000;
        end else if (regRead) begin
            regReadData <= next_readData;
        end else begin
            regReadData <= 32'h0000_0000;
        end
    end
endmodule // uil_interrupt_level_mask_status

// *** rtl/uil_threshold_cross.sv ***
// Threshold crossing detector for one FIFO fill level
`timescale 1ns/1ns
module uil_threshold_cross (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Level selection and FIFO fill
    input wire logic [2:0] levelCode,
    input wire logic [4:0] fillLevel,
    input wire logic isTransmit,
    // One-cycle event on crossing
    output logic crossed
);
    logic inZone; // Level lies on the trigger side of the threshold
    logic inZoneLast; // Previous cycle's zone state
    logic [4:0] threshold; // Threshold in FIFO entries

    // Map the code to eighths of the FIFO; reserved codes fall back to half
    always_comb begin
        case (levelCode)
            3'h0: threshold = 5'h02;
            3'h1: threshold = 5'h04;
            3'h2: threshold = 5'h08;
            3'h3: threshold = 5'h0c;
            3'h4: threshold = 5'h0e;
            default: threshold = 5'h08;
        endcase
        // Receive fires at or above, transmit at or below
        inZone = isTransmit ? (fillLevel <= threshold) : (fillLevel >= threshold);
    end

    // Edge on entry into the zone, so a level that just sits there fires once
    always_ff @(posedge clock) begin
        if (reset) begin
            inZoneLast <= 1'b0;
            crossed <= 1'b0;
        end else begin
            inZoneLast <= inZone;
            crossed <= inZone && !inZoneLast;
        end
    end
endmodule // uil_threshold_cross

// *** shared/uil_pkg.sv ***
// Register map, field layout and reset values for the interrupt level and mask block
package uil_pkg;
    // Register offsets (byte addresses on the register port)
    localparam logic [11:0] TRIGGER_LEVEL_OFFSET = 12'h034;
    localparam logic [11:0] MASK_OFFSET = 12'h038;
    localparam logic [11:0] RAW_STATUS_OFFSET = 12'h03c;
    localparam logic [11:0] MASKED_STATUS_OFFSET = 12'h040;
    localparam logic [11:0] CLEAR_OFFSET = 12'h044;
    // Trigger level register fields
    localparam int RX_LEVEL_LSB = 3;
    localparam int TX_LEVEL_LSB = 0;
    localparam int LEVEL_WIDTH = 3;
    localparam logic [2:0] LEVEL_RESET = 3'h2;
    localparam logic [2:0] LEVEL_MAX_CODE = 3'h4;
    // Interrupt source bit positions
    localparam int SRC_LSB = 4;
    localparam int SRC_COUNT = 7;
    localparam int RX_LEVEL_BIT = 0;
    localparam int TX_LEVEL_BIT = 1;
    localparam int RX_TIMEOUT_BIT = 2;
    localparam int FRAMING_BIT = 3;
    localparam int PARITY_BIT = 4;
    localparam int BREAK_BIT = 5;
    localparam int OVERRUN_BIT = 6;
    localparam logic [6:0] MASK_RESET = 7'h00;
    localparam logic [6:0] RAW_RESET = 7'h00;
    localparam logic [3:0] RAW_LOW_FIELD = 4'hf;
    // FIFO depth seen through the fill level inputs
    localparam int FIFO_DEPTH = 16;
    localparam int FILL_WIDTH = 5;
endpackage

// *** verif/uil_irq_ctrl.sv ***
// Interrupt controller model that counts requests on the level line
`timescale 1ns/1ns
module uil_irq_ctrl (
    // Clock, reset and request line
    input wire logic clock,
    input wire logic reset,
    input wire logic interruptOut,
    // Requests seen so far
    output logic [7:0] requestCount
);
    logic lastLevel; // Line level at the previous edge
    // A level line is taken once per rise, so a held line is one request
    always_ff @(posedge clock) begin
        lastLevel <= reset ? 1'b0 : interruptOut;
        requestCount <= reset ? 8'h00 : requestCount + 8'(interruptOut && !lastLevel);
    end
endmodule // uil_irq_ctrl

// *** verif/uil_props.sv ***
// Port checker for the interrupt level, mask and status block
`timescale 1ns/1ns
module uil_props (
    // Clock, reset and register port
    input wire logic clock,
    input wire logic reset,
    input wire logic [11:0] regAddress,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regReadData,
    // Event and interrupt lines
    input wire logic overrunEvent,
    input wire logic [6:0] maskedInterrupt,
    input wire logic interruptOut
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Decoded strobes
    wire rdRaw = regRead && regAddress == uil_pkg::RAW_STATUS_OFFSET;
    wire wrMask = regWrite && regAddress == uil_pkg::MASK_OFFSET;
    wire rdMask = regRead && regAddress == uil_pkg::MASK_OFFSET;
    wire rdMis = regRead && regAddress == uil_pkg::MASKED_STATUS_OFFSET;
    wire clrOver = regWrite && regAddress == uil_pkg::CLEAR_OFFSET && regWriteData[10];
    read_idle_a: assert property (!regRead |=> regReadData == 32'h0)
        else $error("read data outside read slot");
    raw_low_a: assert property (rdRaw |=> regReadData[3:0] == 4'hf)
        else $error("raw low field not all ones");
    irq_or_a: assert property (interruptOut == |maskedInterrupt)
        else $error("interrupt line differs from masked bits");
    raw_sticky_a: assert property (overrunEvent ##1 !regWrite ##1 rdRaw |=> regReadData[10])
        else $error("overrun raw bit lost");
    mask_block_a: assert property (wrMask && regWriteData[10:4] == 7'h0 |=> maskedInterrupt == 7'h0)
        else $error("zero mask passed an interrupt");
    mask_read_a: assert property (wrMask ##1 !wrMask ##1 rdMask |=>
        regReadData[10:4] == $past(regWriteData[10:4], 3))
        else $error("mask read differs from write");
    mis_read_a: assert property (rdMis |=> regReadData[10:4] == $past(maskedInterrupt))
        else $error("masked status read wrong");
    clear_drop_a: assert property (clrOver && !overrunEvent |=> !maskedInterrupt[6])
        else $error("overrun survived clear");
    // Main scenarios reached
    cover property (interruptOut);
    cover property (clrOver);
    cover property (rdRaw);
endmodule // uil_props
bind uil_interrupt_level_mask_status uil_props chk (.clock(clock), .reset(reset),
    .regAddress(regAddress), .regWriteData(regWriteData), .regWrite(regWrite),
    .regRead(regRead), .regReadData(regReadData), .overrunEvent(overrunEvent),
    .maskedInterrupt(maskedInterrupt), .interruptOut(interruptOut));

// *** verif/uil_testbench.sv ***
// Self-checking bench for the interrupt level, mask and status block
`timescale 1ns/1ns
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected %0t %h %h", $time, (a), (b)); end end
module testbench;
    localparam logic [11:0] RAW = uil_pkg::RAW_STATUS_OFFSET;
    localparam logic [11:0] TRG = uil_pkg::TRIGGER_LEVEL_OFFSET;
    logic clock = 0, reset = 1, regWrite = 0, regRead = 0, rdPend = 0, interruptOut;
    logic [11:0] regAddress = 12'h000;
    logic [31:0] regWriteData = 32'h0, regReadData, exp, head, seed = 32'h8c0f80a2;
    logic [4:0] ev = 5'h00, rxFill = 5'h00, txFill = 5'h10; // Fills start outside zones
    logic [4:0] thr [5] = '{5'h02, 5'h04, 5'h08, 5'h0c, 5'h0e}; // Entries per code
    logic [6:0] maskedInterrupt;
    logic [7:0] reqCount, reqBase;
    logic [31:0] q [$]; // Expected read answers, oldest first
    int mismatches = 0, nTests = 0, cyc = 0;
    always #4 clock = ~clock;
    uil_interrupt_level_mask_status uut (.clock(clock), .reset(reset), .regAddress(regAddress),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .overrunEvent(ev[4]), .breakErrEvent(ev[3]),
        .parityErrEvent(ev[2]), .framingErrEvent(ev[1]), .rxTimeoutEvent(ev[0]),
        .rxFillLevel(rxFill), .txFillLevel(txFill), .maskedInterrupt(maskedInterrupt),
        .interruptOut(interruptOut));
    uil_irq_ctrl ctrl (.clock(clock), .reset(reset), .interruptOut(interruptOut),
        .requestCount(reqCount));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // One bus cycle; a read files its expected answer for the monitor
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddress <= a;
        regWriteData <= d;
        regWrite <= w;
        regRead <= !w;
        if (!w) q.push_back(d);
        @(posedge clock);
        {regWrite, regRead} <= 2'b00;
    endtask
    task automatic stop_test();
        if (mismatches == 0 && nTests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Read data stands only in the cycle after the strobe, so look mid-cycle
    always @(posedge clock) rdPend <= regRead;
    always @(negedge clock) if (rdPend) begin
        head = q.pop_front();
        `CHK(regReadData, head)
    end
    // Hang guard, far above the roughly 160 cycles the run needs
    always @(posedge clock) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        bus(0, TRG, 32'h12);
        bus(0, uil_pkg::MASK_OFFSET, 32'h0);
        bus(0, RAW, 32'hf);
        bus(1, uil_pkg::MASK_OFFSET, 32'h0);
        bus(1, RAW, 32'hffffffff);
        bus(0, RAW, 32'hf);
        // Codes 0 to 4 in both fields; upper bits written and read as zero
        for (int c = 0; c < 5; c++) begin
            bus(1, TRG, {26'h0, 3'(c), 3'(4 - c)});
            bus(0, TRG, {26'h0, 3'(c), 3'(4 - c)});
        end
        // Each timeout and error event pulses once and must stick
        for (int i = 0; i < 5; i++) begin
            @(posedge clock);
            ev <= 5'(1 << i);
            @(posedge clock);
            ev <= 5'h00;
            bus(0, RAW, 32'hf | (((32'h2 << i) - 32'h1) << 6));
        end
        `CHK(interruptOut, 1'b0)
        exp = rnd();
        bus(1, uil_pkg::MASK_OFFSET, exp);
        bus(0, uil_pkg::MASK_OFFSET, exp & 32'h7f0);
        bus(0, uil_pkg::MASKED_STATUS_OFFSET, exp & 32'h7c0);
        `CHK(interruptOut, |exp[10:6])
        `CHK(maskedInterrupt, exp[10:4] & 7'h7c)
        bus(1, uil_pkg::CLEAR_OFFSET, 32'h0);
        bus(0, RAW, 32'h7cf);
        bus(1, uil_pkg::CLEAR_OFFSET, 32'h7c0);
        bus(0, RAW, 32'hf);
        // Receive level per code: below, on and held at the threshold
        bus(1, uil_pkg::MASK_OFFSET, 32'h10);
        reqBase = reqCount;
        for (int c = 0; c < 5; c++) begin
            bus(1, TRG, {26'h0, 3'(c), 3'h2});
            rxFill <= thr[c] - 5'h1;
            repeat (3) @(posedge clock);
            bus(0, RAW, 32'hf);
            rxFill <= thr[c];
            repeat (3) @(posedge clock);
            bus(0, RAW, 32'h1f);
            bus(1, uil_pkg::CLEAR_OFFSET, 32'h10);
            bus(0, RAW, 32'hf);
            rxFill <= 5'h00;
        end
        `CHK(reqCount, reqBase + 8'h05)
        txFill <= 5'h08;
        repeat (3) @(posedge clock);
        bus(0, RAW, 32'h2f);
        repeat (3) @(posedge clock);
        stop_test();
    end
endmodule // testbench
